// file: rtl/mcs_pkg.sv
// constants shared by the microcontroller core shell
// assumes a single 100 MHz clock and an active-low reset
package mcs_pkg;
    localparam int         UNITS_DEFAULT  = 1;
    localparam int         UNITS_MIN      = 1;
    localparam int         UNITS_MAX      = 256;
    localparam int         PORT_COUNT     = 4;
    localparam int         PORT_W         = 8;
    localparam logic [7:0] PORT_RESET     = 8'hFF;
    localparam int         SER_MODE_W     = 2;
    localparam logic [1:0] SER_MODE_SHIFT = 2'h0;
    localparam logic       SER_LINE_IDLE  = 1'h1;
    localparam logic       IRQ_LINE_IDLE  = 1'h1;
    localparam int         ROM_AW         = 16;
    localparam int         RAM_AW         = 16;
    localparam int         MEM_DW         = 8;
endpackage

// file: rtl/mcs_sync2.sv
// two-stage level synchroniser for a vector of lines
// assumes the lines may change at any time relative to clk
`timescale 1ns/1ps
`default_nettype none
module mcs_sync2 #(
    parameter int   WIDTH     = 1,
    parameter logic RESET_VAL = 1'h1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // lines
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // ****************************************************
    // configuration check
    // ****************************************************
    generate
        if (WIDTH < 1) begin : g_bad
            $error("synchroniser needs at least one line");
        end
    endgenerate

    // first stage feeds only the second
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= {WIDTH{RESET_VAL}};
            sync_reg <= {WIDTH{RESET_VAL}};
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule // mcs_sync2
`default_nettype wire

// file: rtl/mcs_core_shell.sv
// pin-facing shell of the microcontroller core
// assumes synchronous memories and timing constraints on memory ports
//
// Functional notes
// - all storage is clocked on the rising edge of clk only.
// - reset acts without the clock and sets every flip-flop to a constant.
// - one clock, never gated and never passed through logic.
// - each external interrupt line passes two flip-flops before use.
// - parallel port inputs reach the core with no synchroniser.
// - memory signals pass between core and memories unregistered.
// - the receive-line direction is high while the pin drives out.
// - the receive-line data output carries data only in shift mode 0.
// - each serial unit has its own transmit output and receive input.
// - each parallel port has a separate input bus and output bus.
`timescale 1ns/1ps
`default_nettype none
module mcs_core_shell #(
    parameter int unit_count_generic = mcs_pkg::UNITS_DEFAULT
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // timer count pins
    input  wire logic [unit_count_generic-1:0] timer0_count_inputs,
    input  wire logic [unit_count_generic-1:0] timer1_count_inputs,
    // external interrupt pins
    input  wire logic [unit_count_generic-1:0] ext_irq_a_inputs,
    input  wire logic [unit_count_generic-1:0] ext_irq_b_inputs,
    // serial pins
    input  wire logic [unit_count_generic-1:0] serial_rxd_in,
    output var  logic [unit_count_generic-1:0] serial_txd_out,
    output var  logic [unit_count_generic-1:0] serial_rxd_out,
    output var  logic [unit_count_generic-1:0] serial_rxd_dir,
    // parallel port pins
    input  wire logic [7:0]                    port_a_in,
    input  wire logic [7:0]                    port_b_in,
    input  wire logic [7:0]                    port_c_in,
    input  wire logic [7:0]                    port_d_in,
    output var  logic [7:0]                    port_a_out,
    output var  logic [7:0]                    port_b_out,
    output var  logic [7:0]                    port_c_out,
    output var  logic [7:0]                    port_d_out,
    // core side: timer and interrupt views
    output var  logic [unit_count_generic-1:0] core_timer0_count,
    output var  logic [unit_count_generic-1:0] core_timer1_count,
    output var  logic [unit_count_generic-1:0] core_irq_a,
    output var  logic [unit_count_generic-1:0] core_irq_b,
    // core side: serial units
    input  wire logic [2*unit_count_generic-1:0] core_ser_mode,
    input  wire logic [unit_count_generic-1:0] core_ser_txd,
    input  wire logic [unit_count_generic-1:0] core_ser_shift_data,
    input  wire logic [unit_count_generic-1:0] core_ser_shift_drive,
    output var  logic [unit_count_generic-1:0] core_ser_rxd,
    // core side: port latches
    input  wire logic [3:0]                    core_port_wr,
    input  wire logic [7:0]                    core_port_wdata,
    input  wire logic [1:0]                    core_port_rsel,
    input  wire logic                          core_port_rlatch,
    output var  logic [7:0]                    core_port_rdata,
    // core side: memory requests
    input  wire logic [15:0]                   core_rom_addr,
    output var  logic [7:0]                    core_rom_data,
    input  wire logic [15:0]                   core_ram_addr,
    input  wire logic [7:0]                    core_ram_wdata,
    input  wire logic                          core_ram_we,
    output var  logic [7:0]                    core_ram_rdata,
    // memory blocks
    output var  logic [15:0]                   rom_addr,
    input  wire logic [7:0]                    rom_data,
    output var  logic [15:0]                   ram_addr,
    output var  logic [7:0]                    ram_wdata,
    output var  logic                          ram_we,
    input  wire logic [7:0]                    ram_rdata
);
    localparam int N = unit_count_generic;

    // ****************************************************
    // configuration check
    // ****************************************************
    generate
        if (N < mcs_pkg::UNITS_MIN || N > mcs_pkg::UNITS_MAX) begin : g_bad
            $error("unit count out of range");
        end
        // pins below are wired by hand to these shapes
        if (mcs_pkg::PORT_COUNT != 4
            || mcs_pkg::PORT_W != 8) begin : g_bad_port
            $error("port shape does not fit the pins");
        end
        if (mcs_pkg::ROM_AW != 16 || mcs_pkg::RAM_AW != 16
            || mcs_pkg::MEM_DW != 8) begin : g_bad_mem
            $error("memory bus shape does not fit the pins");
        end
        if (mcs_pkg::SER_MODE_W != 2) begin : g_bad_mode
            $error("serial mode field must be two bits");
        end
    endgenerate

    // ****************************************************
    // decoding
    // ****************************************************
    function automatic logic is_shift_mode(input logic [1:0] mode);
        is_shift_mode = (mode == mcs_pkg::SER_MODE_SHIFT);
    endfunction

    // ****************************************************
    // interrupt synchronisers
    // ****************************************************
    // other clock domains may drive these pins
    mcs_sync2 #(
        .WIDTH     (2*N),
        .RESET_VAL (mcs_pkg::IRQ_LINE_IDLE)
    ) u_irq_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in ({ext_irq_b_inputs, ext_irq_a_inputs}),
        .sync_out ({core_irq_b, core_irq_a})
    );

    // counter pins are edge-detected inside the timer units
    assign core_timer0_count = timer0_count_inputs;
    assign core_timer1_count = timer1_count_inputs;

    // ****************************************************
    // serial pins
    // ****************************************************
    logic [N-1:0] txd_reg;
    logic [N-1:0] txd_next;
    logic [N-1:0] rxdo_reg;
    logic [N-1:0] rxdo_next;
    logic [N-1:0] rdir_reg;
    logic [N-1:0] rdir_next;

    genvar u;
    generate
        for (u = 0; u < N; u++) begin : g_ser
            always_comb begin
                txd_next[u]  = core_ser_txd[u];
                // outside mode 0 the line just idles high
                rxdo_next[u] = is_shift_mode(core_ser_mode[2*u +: 2])
                               ? core_ser_shift_data[u]
                               : mcs_pkg::SER_LINE_IDLE;
                rdir_next[u] = is_shift_mode(core_ser_mode[2*u +: 2])
                               & core_ser_shift_drive[u];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txd_reg  <= {N{mcs_pkg::SER_LINE_IDLE}};
            rxdo_reg <= {N{mcs_pkg::SER_LINE_IDLE}};
            rdir_reg <= '0;
        end else begin
            txd_reg  <= txd_next;
            rxdo_reg <= rxdo_next;
            rdir_reg <= rdir_next;
        end
    end

    assign serial_txd_out = txd_reg;
    assign serial_rxd_out = rxdo_reg;
    assign serial_rxd_dir = rdir_reg;
    // receive line is synchronised inside the serial unit
    assign core_ser_rxd   = serial_rxd_in;

    // ****************************************************
    // parallel ports
    // ****************************************************
    logic [7:0] port_reg  [mcs_pkg::PORT_COUNT];
    logic [7:0] port_next [mcs_pkg::PORT_COUNT];
    logic [7:0] pin_view  [mcs_pkg::PORT_COUNT];

    // pins used raw: a user with async sources adds sync outside
    assign pin_view[0] = port_a_in;
    assign pin_view[1] = port_b_in;
    assign pin_view[2] = port_c_in;
    assign pin_view[3] = port_d_in;

    genvar p;
    generate
        for (p = 0; p < mcs_pkg::PORT_COUNT; p++) begin : g_port
            always_comb begin
                port_next[p] = core_port_wr[p] ? core_port_wdata
                                               : port_reg[p];
            end
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    port_reg[p] <= mcs_pkg::PORT_RESET;
                end else begin
                    port_reg[p] <= port_next[p];
                end
            end
        end
    endgenerate

    // read-modify-write reads the latch, plain reads the pins
    always_comb begin
        if (core_port_rlatch) begin
            core_port_rdata = port_reg[core_port_rsel];
        end else begin
            core_port_rdata = pin_view[core_port_rsel];
        end
    end

    assign port_a_out = port_reg[0];
    assign port_b_out = port_reg[1];
    assign port_c_out = port_reg[2];
    assign port_d_out = port_reg[3];

    // ****************************************************
    // memory interface
    // ****************************************************
    // no retiming here: costs timing budget, saves a wait cycle
    assign rom_addr       = core_rom_addr;
    assign core_rom_data  = rom_data;
    assign ram_addr       = core_ram_addr;
    assign ram_wdata      = core_ram_wdata;
    assign ram_we         = core_ram_we;
    assign core_ram_rdata = ram_rdata;
endmodule // mcs_core_shell
`default_nettype wire

// file: testbench/mcs_mem_model.sv
// synchronous program and data memory stand-in for the shell
// assumes addresses and write strobe settle before the rising edge
`timescale 1ns/1ps
`default_nettype none
module mcs_mem_model (
    // clock
    input  wire logic        clk,
    // program memory
    input  wire logic [15:0] rom_addr,
    output var  logic [7:0]  rom_data,
    // data memory
    input  wire logic [15:0] ram_addr,
    input  wire logic [7:0]  ram_wdata,
    input  wire logic        ram_we,
    output var  logic [7:0]  ram_rdata
);
    logic [7:0] ram_reg [0:255];
    // registered reads, as the shell relies on synchronous memories
    always_ff @(posedge clk) begin
        rom_data  <= rom_addr[7:0] ^ 8'hA5;
        ram_rdata <= ram_reg[ram_addr[7:0]];
        if (ram_we) begin
            ram_reg[ram_addr[7:0]] <= ram_wdata;
        end
    end
endmodule // mcs_mem_model
`default_nettype wire

// file: testbench/mcs_core_shell_asserts.sv
// port-level checks of the core shell
// assumes one clock and the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module mcs_core_shell_asserts #(
    parameter int unit_count_generic = 1
) (
    input wire logic                            clk,
    input wire logic                            rstn,
    input wire logic [unit_count_generic-1:0]   ext_irq_a_inputs,
    input wire logic [unit_count_generic-1:0]   core_irq_a,
    input wire logic [unit_count_generic-1:0]   core_ser_txd,
    input wire logic [unit_count_generic-1:0]   serial_txd_out,
    input wire logic [2*unit_count_generic-1:0] core_ser_mode,
    input wire logic [unit_count_generic-1:0]   core_ser_shift_data,
    input wire logic [unit_count_generic-1:0]   core_ser_shift_drive,
    input wire logic [unit_count_generic-1:0]   serial_rxd_out,
    input wire logic [unit_count_generic-1:0]   serial_rxd_dir,
    input wire logic [unit_count_generic-1:0]   serial_rxd_in,
    input wire logic [unit_count_generic-1:0]   core_ser_rxd,
    input wire logic [3:0]                      core_port_wr,
    input wire logic [7:0]                      core_port_wdata,
    input wire logic [7:0]                      port_a_out,
    input wire logic [7:0]                      port_b_out,
    input wire logic [7:0]                      port_a_in,
    input wire logic [1:0]                      core_port_rsel,
    input wire logic                            core_port_rlatch,
    input wire logic [7:0]                      core_port_rdata,
    input wire logic [15:0]                     core_rom_addr,
    input wire logic [15:0]                     rom_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // edges since release; $past would otherwise see reset-time values
    logic [1:0] up_reg;
    logic [1:0] up_next;
    always_comb up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) up_reg <= 2'h0;
        else up_reg <= up_next;
    property p_irq_sync;
        up_reg >= 2'h2 |-> core_irq_a == $past(ext_irq_a_inputs, 2);
    endproperty
    a_irq_sync: assert property (p_irq_sync) else $error("irq sync");
    property p_txd;
        up_reg != 2'h0 |-> serial_txd_out == $past(core_ser_txd);
    endproperty
    a_txd: assert property (p_txd) else $error("txd copy");
    property p_shift;
        up_reg != 2'h0 && $past(core_ser_mode[1:0]) == 2'h0 |->
            serial_rxd_out[0] == $past(core_ser_shift_data[0])
            && serial_rxd_dir[0] == $past(core_ser_shift_drive[0]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("shift mode");
    property p_idle;
        up_reg != 2'h0 && $past(core_ser_mode[1:0]) != 2'h0 |->
            serial_rxd_out[0] && !serial_rxd_dir[0];
    endproperty
    a_idle: assert property (p_idle) else $error("not shift mode");
    property p_port_wr;
        core_port_wr[0] |=> port_a_out == $past(core_port_wdata);
    endproperty
    a_port_wr: assert property (p_port_wr)
        else $error("port write");
    property p_port_hold;
        !core_port_wr[1] |=> $stable(port_b_out);
    endproperty
    a_port_hold: assert property (p_port_hold)
        else $error("port hold");
    property p_pin_read;
        core_port_rsel == 2'h0 && !core_port_rlatch |->
            core_port_rdata == port_a_in;
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin read");
    property p_wires;
        core_ser_rxd == serial_rxd_in && rom_addr == core_rom_addr;
    endproperty
    a_wires: assert property (p_wires)
        else $error("wire path");
    property p_async_rst;
        disable iff (1'b0) !rstn |-> port_a_out == 8'hFF
            && serial_rxd_dir == '0 && core_irq_a == '1;
    endproperty
    a_async_rst: assert property (p_async_rst) else $error("reset");
    c_wr: cover property (core_port_wr[0]);
    c_shift: cover property (core_ser_mode[1:0] == 2'h0
        && core_ser_shift_drive[0]);
    // the bench pulls lines a0 and b1 low after reset; only a0 is covered here
    c_irq: cover property ($fell(core_irq_a[0]));
endmodule // mcs_core_shell_asserts
bind mcs_core_shell mcs_core_shell_asserts #(
    .unit_count_generic(unit_count_generic)) u_chk (.*);
`default_nettype wire

// file: testbench/mcs_core_shell_tb.sv
// self-checking bench of the core shell with two units
// assumes the memory model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module mcs_core_shell_tb;
    localparam int N = 2;
    typedef struct packed {
        logic [3:0] md;
        logic [1:0] sd, dr, tx, eo, ed;
    } mcs_row_t;
    // every serial mode appears on some unit
    mcs_row_t rows [4] = '{'{4'h0, 2'h1, 2'h3, 2'h1, 2'h1, 2'h3},
        '{4'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2},
        '{4'h6, 2'h0, 2'h3, 2'h0, 2'h3, 2'h0},
        '{4'hC, 2'h0, 2'h1, 2'h3, 2'h2, 2'h1}};
    logic clk = 1'h0;
    logic rstn = 1'h1;
    logic [N-1:0] timer0_count_inputs, timer1_count_inputs, ext_irq_a_inputs;
    logic [N-1:0] ext_irq_b_inputs, serial_rxd_in, serial_txd_out;
    logic [N-1:0] serial_rxd_out, serial_rxd_dir, core_timer0_count;
    logic [N-1:0] core_timer1_count, core_irq_a, core_irq_b, core_ser_txd;
    logic [N-1:0] core_ser_shift_data, core_ser_shift_drive, core_ser_rxd;
    logic [2*N-1:0] core_ser_mode;
    logic [7:0] port_a_in, port_b_in, port_c_in, port_d_in, port_a_out;
    logic [7:0] port_b_out, port_c_out, port_d_out, core_port_wdata;
    logic [7:0] core_port_rdata, core_rom_data, rom_data, core_ram_wdata;
    logic [7:0] core_ram_rdata, ram_wdata, ram_rdata;
    logic [15:0] core_rom_addr, rom_addr, core_ram_addr, ram_addr;
    logic [3:0] core_port_wr;
    logic [1:0] core_port_rsel;
    logic core_port_rlatch, core_ram_we, ram_we;
    int bad_count = 0;
    int n_tests = 0;
    mcs_core_shell #(.unit_count_generic(N)) uut (.*);
    mcs_mem_model u_mem (.*);
    always #5 clk = ~clk;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // generous bound; the sequence needs well under 100 cycles
    initial begin
        #50000;
        bad_count++;
        summarize();
    end
    initial begin
        {timer0_count_inputs, timer1_count_inputs, serial_rxd_in} = '0;
        {ext_irq_a_inputs, ext_irq_b_inputs, core_ser_mode} = '1;
        {core_ser_txd, core_ser_shift_data, core_ser_shift_drive} = '0;
        {core_port_wr, core_port_wdata, core_port_rsel, core_port_rlatch} = '0;
        {core_rom_addr, core_ram_addr, core_ram_wdata, core_ram_we} = '0;
        {port_a_in, port_b_in, port_c_in, port_d_in} = 32'h11223344;
        #1 rstn = 1'h0;
        tick(20);
        rstn = 1'h1;
        foreach (rows[i]) begin
            core_ser_mode = rows[i].md;
            core_ser_shift_data = rows[i].sd;
            core_ser_shift_drive = rows[i].dr;
            core_ser_txd = rows[i].tx;
            tick(1);
            chk(serial_rxd_out, rows[i].eo, "shift data");
            chk(serial_rxd_dir, rows[i].ed, "direction");
            chk(serial_txd_out, rows[i].tx, "transmit");
        end
        serial_rxd_in = 2'h2;
        timer0_count_inputs = 2'h1;
        timer1_count_inputs = 2'h2;
        ext_irq_a_inputs = 2'h2;
        ext_irq_b_inputs = 2'h1;
        #1 chk(core_ser_rxd, 2'h2, "receive");
        chk({core_timer0_count, core_timer1_count}, 4'h6, "timer");
        tick(1);
        chk(core_irq_a, 2'h3, "irq early");
        tick(1);
        chk({core_irq_a, core_irq_b}, 4'h9, "irq late");
        // back-to-back writes, one port per edge
        for (int p = 0; p < 4; p++) begin
            core_port_wr = 4'h1 << p;
            core_port_wdata = 8'(8'h5A + p);
            tick(1);
        end
        core_port_wr = 4'h0;
        chk({port_a_out, port_b_out}, 16'h5A5B, "ports a b");
        chk({port_c_out, port_d_out}, 16'h5C5D, "ports c d");
        // inputs move only just after an edge, as everywhere else
        for (int p = 0; p < 4; p++) begin
            core_port_rsel = 2'(p);
            core_port_rlatch = 1'h1;
            tick(1);
            chk(core_port_rdata, 8'(8'h5A + p), "latch read");
            core_port_rlatch = 1'h0;
            tick(1);
            chk(core_port_rdata, 8'(8'h11 * (p + 1)), "pin read");
        end
        core_rom_addr = 16'h0012;
        core_ram_addr = 16'h0034;
        core_ram_wdata = 8'hC3;
        core_ram_we = 1'h1;
        tick(1);
        core_ram_we = 1'h0;
        tick(1);
        chk(core_rom_data, 8'hB7, "rom data");
        chk(core_ram_rdata, 8'hC3, "ram data");
        core_port_wr = 4'h1;
        core_port_wdata = 8'h00;
        tick(1);
        // reset mid-cycle must act before the next edge
        rstn = 1'h0;
        #1 chk(port_a_out, 8'hFF, "async reset");
        tick(2);
        rstn = 1'h1;
        tick(2);
        chk(port_a_out, 8'h00, "after reset");
        chk(core_irq_a, 2'h2, "irq after reset");
        summarize();
    end
endmodule // mcs_core_shell_tb
`default_nettype wire
